// file: logic/cop_core_ctrl.v
// Behaviour
// - Write-only 8-bit option register, loaded from working register by option-load.
// - Any reset sets all option bits to one.
// - Output direction disables pull-up and wake-up on that pin.
// - External counter clock source forces counter clock pin to input.
// - Option bit 7 low enables pin-change wake-up.
// - Option bit 6 low enables weak pull-ups.
// - Bit 5 picks external pin or instruction clock for tick counter.
// - Bit 4 one counts falling edges, zero rising edges.
// - Bit 3 gives prescaler to watchdog when one, tick counter when zero.
// - Rate n divides by 2^(n+1) for counter, 2^n for watchdog.
// - Trim register holds 7-bit signed value in bits 7:1; bit 0 reads zero.
// - Program counter increments each cycle unless loaded.
// - Jump loads bits 8:0 from instruction, bit 9 from page bit.
// - Call or low-byte write loads bits 7:0 and clears bit 8.
// - Reset sets counter to all ones; it then wraps to zero.
// - Reset clears the page preselect bit.
// - Two-deep twelve-bit return stack, reached only by call and return.
// - Call copies level 1 to level 2, then pushes counter plus one.
// - Return loads counter from level 1, level 2 into level 1, literal to W.
// - No stack overflow or underflow status is given.
// - Indirect location accesses the register addressed by the pointer.
// - Pointer zero reads 00h and writes nothing.
// - Page bit one selects 200h-3FFh, zero 000h-1FFh.
// - Pointer low five bits address data 00h to 1Fh.
`timescale 1ns/1ps
`include "cop_defs.vh"

module cop_core_ctrl (
  // Clock and reset
  input  wire                    ref_clk,
  input  wire                    rst,
  // Execution path strobes
  input  wire                    exec_option_load,
  input  wire                    exec_jump,
  input  wire                    exec_call,
  input  wire                    exec_return,
  input  wire                    exec_pcl_write,
  input  wire                    exec_dir_load,
  input  wire [8:0]              instr_addr,
  input  wire [7:0]              instr_literal,
  input  wire [7:0]              alu_result,
  input  wire [7:0]              work_reg,
  // Data file access
  input  wire                    file_wr,
  input  wire [4:0]              file_addr,
  input  wire [7:0]              file_wdata,
  output reg  [7:0]              file_rdata_q,
  // Data memory side
  output reg                     mem_wr_q,
  output reg  [4:0]              mem_addr_q,
  output reg  [7:0]              mem_wdata_q,
  input  wire [7:0]              mem_rdata,
  // Program side
  output reg  [`COP_PC_W-1:0]    program_counter_q,
  output reg                     work_load_q,
  output reg  [7:0]              work_data_q,
  output reg  [7:0]              oscillator_trim_q,
  // Pins and tick path
  input  wire [5:0]              pin_change,
  input  wire                    counter_clock_pin,
  input  wire                    cycle_tick,
  input  wire                    watchdog_tick,
  output reg  [5:0]              pullup_en_q,
  output reg                     wake_q,
  output reg  [5:0]              dir_q,
  output reg                     counter_inc_q,
  output reg                     watchdog_inc_q,
  output reg  [2:0]              prescaler_rate_q
);

  localparam CLK_PIN_IDX = 2;

  reg  [7:0]  option_q;
  reg         page_preselect_q;
  reg  [7:0]  pointer_q;
  reg  [7:0]  status_low_q;
  reg  [5:0]  direction_control_q;
  reg  [5:0]  chg_s1_q, chg_s2_q;
  reg         clk_s1_q, clk_s2_q, clk_s3_q;
  wire [`COP_STACK_W-1:0] stack_top;
  wire [`COP_PC_W-1:0]    pc_plus1 = program_counter_q + 10'h001;
  wire        pre_out;

  wire pin_change_wake_disable   = option_q[`COP_OPT_WAKE_DIS];
  wire pullup_disable            = option_q[`COP_OPT_PULL_DIS];
  wire counter_clock_source_sel  = option_q[`COP_OPT_CLK_SRC];
  wire counter_edge_sel          = option_q[`COP_OPT_EDGE];
  wire prescaler_assign          = option_q[`COP_OPT_PS_ASSIGN];
  wire [2:0] prescaler_rate      = option_q[`COP_OPT_RATE_HI:`COP_OPT_RATE_LO];

  // Indirect target, pointer zero folds back to itself
  wire [4:0] eff_addr   = (file_addr == `COP_ADDR_INDIRECT) ? pointer_q[4:0] : file_addr;
  wire       null_ind   = (file_addr == `COP_ADDR_INDIRECT) && (pointer_q[4:0] == 5'h00);

  // Option register, write only
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      option_q <= `COP_OPTION_RST;
    end else if (exec_option_load) begin
      option_q <= work_reg;
    end
  end

  // Direction latch, set to inputs on reset
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      direction_control_q <= `COP_DIR_RST;
    end else if (exec_dir_load) begin
      direction_control_q <= work_reg[5:0];
    end
  end

  // Program counter and stack
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      program_counter_q <= `COP_PC_RST;
    end else if (exec_return) begin
      program_counter_q <= stack_top[`COP_PC_W-1:0];
    end else if (exec_jump) begin
      program_counter_q <= {page_preselect_q, instr_addr};
    end else if (exec_call) begin
      program_counter_q <= {page_preselect_q, 1'b0, alu_result};
    end else if (exec_pcl_write) begin
      program_counter_q <= {page_preselect_q, 1'b0, alu_result};
    end else begin
      program_counter_q <= pc_plus1;
    end
  end

  cop_ret_stack u_stack (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .push      (exec_call),
    .pop       (exec_return),
    .push_data ({2'b00, pc_plus1}),
    .top       (stack_top)
  );

  // Return literal into W
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      work_load_q <= 1'b0;
      work_data_q <= 8'h00;
    end else begin
      work_load_q <= exec_return;
      work_data_q <= exec_return ? instr_literal : work_data_q;
    end
  end

  // File registers owned here
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      page_preselect_q  <= 1'b0;
      pointer_q         <= 8'he0;
      oscillator_trim_q <= {`COP_TRIM_RST, 1'b0};
      status_low_q      <= 8'h18;
    end else if (file_wr && !null_ind) begin
      case (eff_addr)
        `COP_ADDR_STATUS: begin
          page_preselect_q <= file_wdata[`COP_STATUS_PAGE];
          status_low_q     <= file_wdata;
        end
        `COP_ADDR_POINTER: pointer_q <= {3'b111, file_wdata[4:0]};
        `COP_ADDR_OSC_TRIM: oscillator_trim_q <= {file_wdata[7:1], 1'b0};
        default: ;
      endcase
    end
  end

  // Reads and data memory port
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      file_rdata_q <= 8'h00;
      mem_wr_q     <= 1'b0;
      mem_addr_q   <= 5'h00;
      mem_wdata_q  <= 8'h00;
    end else begin
      mem_wr_q    <= file_wr && !null_ind && (eff_addr > `COP_ADDR_OSC_TRIM);
      mem_addr_q  <= eff_addr;
      mem_wdata_q <= file_wdata;
      if (null_ind) begin
        file_rdata_q <= 8'h00;
      end else begin
        case (eff_addr)
          `COP_ADDR_PC_LOW:   file_rdata_q <= program_counter_q[7:0];
          `COP_ADDR_STATUS:   file_rdata_q <= {status_low_q[7:6], page_preselect_q, status_low_q[4:0]};
          `COP_ADDR_POINTER:  file_rdata_q <= pointer_q;
          `COP_ADDR_OSC_TRIM: file_rdata_q <= oscillator_trim_q;
          default:            file_rdata_q <= mem_rdata;
        endcase
      end
    end
  end

  // Pin synchronisers
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chg_s1_q <= 6'h00;
      chg_s2_q <= 6'h00;
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
    end else begin
      chg_s1_q <= pin_change;
      chg_s2_q <= chg_s1_q;
      clk_s1_q <= counter_clock_pin;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
    end
  end

  // Edge choice on the counter clock pin
  wire pin_edge = counter_edge_sel ? (clk_s3_q & ~clk_s2_q) : (~clk_s3_q & clk_s2_q);
  wire src_tick = counter_clock_source_sel ? pin_edge : cycle_tick;
  wire pre_in   = prescaler_assign ? watchdog_tick : src_tick;

  cop_prescale u_pre (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .to_watchdog (prescaler_assign),
    .rate        (prescaler_rate),
    .tick_in     (pre_in),
    .tick_out    (pre_out)
  );

  // Pin control and tick outputs
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pullup_en_q      <= 6'h00;
      wake_q           <= 1'b0;
      dir_q            <= `COP_DIR_RST;
      counter_inc_q    <= 1'b0;
      watchdog_inc_q   <= 1'b0;
      prescaler_rate_q <= 3'h7;
    end else begin
      pullup_en_q <= {6{~pullup_disable}} & direction_control_q;
      wake_q      <= ~pin_change_wake_disable & |(chg_s2_q & direction_control_q);
      dir_q       <= direction_control_q;
      if (counter_clock_source_sel) begin
        dir_q[CLK_PIN_IDX] <= 1'b1;
      end
      counter_inc_q    <= prescaler_assign ? src_tick : pre_out;
      watchdog_inc_q   <= prescaler_assign ? pre_out : watchdog_tick;
      prescaler_rate_q <= prescaler_rate;
    end
  end

endmodule // cop_core_ctrl

// file: logic/cop_defs.vh
`ifndef COP_DEFS_VH
`define COP_DEFS_VH

// Data file locations
`define COP_ADDR_INDIRECT   5'h00
`define COP_ADDR_PC_LOW     5'h02
`define COP_ADDR_STATUS     5'h03
`define COP_ADDR_POINTER    5'h04
`define COP_ADDR_OSC_TRIM   5'h05

// Option field positions
`define COP_OPT_WAKE_DIS    7
`define COP_OPT_PULL_DIS    6
`define COP_OPT_CLK_SRC     5
`define COP_OPT_EDGE        4
`define COP_OPT_PS_ASSIGN   3
`define COP_OPT_RATE_HI     2
`define COP_OPT_RATE_LO     0
`define COP_STATUS_PAGE     5

// Reset values
`define COP_OPTION_RST      8'hff
`define COP_PC_RST          10'h3ff
`define COP_TRIM_RST        7'h7f
`define COP_DIR_RST         6'h3f

// Widths
`define COP_PC_W            10
`define COP_STACK_W         12

`endif

// file: logic/cop_ret_stack.v
`timescale 1ns/1ps
`include "cop_defs.vh"

module cop_ret_stack (
  // Clock and reset
  input  wire                      ref_clk,
  input  wire                      rst,
  // Control
  input  wire                      push,
  input  wire                      pop,
  input  wire [`COP_STACK_W-1:0]   push_data,
  output wire [`COP_STACK_W-1:0]   top
);

  reg [`COP_STACK_W-1:0] level1_q;
  reg [`COP_STACK_W-1:0] level2_q;

  // No overflow or underflow flag exists
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      level1_q <= {`COP_STACK_W{1'b0}};
      level2_q <= {`COP_STACK_W{1'b0}};
    end else if (push) begin
      level2_q <= level1_q;
      level1_q <= push_data;
    end else if (pop) begin
      level1_q <= level2_q;
    end
  end

  assign top = level1_q;

endmodule // cop_ret_stack

// file: logic/cop_prescale.v
`timescale 1ns/1ps
`include "cop_defs.vh"

module cop_prescale (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // Configuration
  input  wire       to_watchdog,
  input  wire [2:0] rate,
  // Event in, divided event out
  input  wire       tick_in,
  output reg        tick_out
);

  reg [7:0] count_q;
  wire [7:0] count_d = count_q + 8'h01;

  // Terminal mask is 2^(n+1)-1 for the counter, 2^n-1 for the watchdog
  function [7:0] div_mask;
    input [2:0] n;
    input       wdt;
    reg   [8:0] full;
    begin
      full = (9'h002 << n) - 9'h001;
      div_mask = wdt ? full[8:1] : full[7:0];
    end
  endfunction

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_q  <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if ((count_q & div_mask(rate, to_watchdog)) == div_mask(rate, to_watchdog)) begin
          count_q  <= 8'h00;
          tick_out <= 1'b1;
        end else begin
          count_q <= count_d;
        end
      end
    end
  end

endmodule // cop_prescale

// file: tb/cop_core_chk.sv
`timescale 1ns/1ps
`include "cop_defs.vh"

module cop_core_chk (
  // Clock and reset
  input wire                 ref_clk,
  input wire                 rst,
  // Execution strobes
  input wire                 exec_option_load,
  input wire                 exec_jump,
  input wire                 exec_call,
  input wire                 exec_return,
  input wire                 exec_pcl_write,
  input wire [8:0]           instr_addr,
  input wire [7:0]           instr_literal,
  input wire [7:0]           alu_result,
  input wire [7:0]           work_reg,
  input wire                 file_wr,
  // Observed outputs
  input wire                 mem_wr_q,
  input wire [4:0]           mem_addr_q,
  input wire [`COP_PC_W-1:0] program_counter_q,
  input wire                 work_load_q,
  input wire [7:0]           work_data_q,
  input wire [7:0]           oscillator_trim_q,
  input wire [5:0]           pullup_en_q,
  input wire [2:0]           prescaler_rate_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire any_load = exec_jump | exec_call | exec_return | exec_pcl_write;

  wire [2:0] wr_rate = work_reg[2:0];

  // Option lands one edge after the load, the rate output one edge later
  property opt_load_p;
    exec_option_load |-> ##2 prescaler_rate_q == $past(wr_rate, 2);
  endproperty

  AST_OPT_RESET: assert property ($fell(rst) |-> prescaler_rate_q == 3'h7 && pullup_en_q == 6'h00)
    else $error("option not all ones after reset");
  AST_OPT_LOAD: assert property (opt_load_p)
    else $error("option rate not loaded from work register");
  AST_PC_INC: assert property (!any_load |=> program_counter_q == $past(program_counter_q) + 10'h001)
    else $error("counter did not advance by one");
  AST_JUMP: assert property (exec_jump && !exec_return |=> program_counter_q[8:0] == $past(instr_addr))
    else $error("jump target wrong");
  AST_CALL: assert property (exec_call && !exec_return && !exec_jump |=>
    program_counter_q[8:0] == {1'b0, $past(alu_result)})
    else $error("call target wrong");
  AST_PCL: assert property (exec_pcl_write && !(exec_jump | exec_call | exec_return) |=>
    program_counter_q[8:0] == {1'b0, $past(alu_result)})
    else $error("low byte write target wrong");
  AST_RET_W: assert property (exec_return |=> work_load_q && work_data_q == $past(instr_literal))
    else $error("return literal not delivered");
  AST_WLOAD_SRC: assert property (work_load_q |-> $past(exec_return))
    else $error("literal load without return");
  AST_TRIM_B0: assert property (##1 oscillator_trim_q[0] == 1'b0)
    else $error("trim bit 0 not zero");
  AST_MEM_WR: assert property (mem_wr_q |-> $past(file_wr) && mem_addr_q != 5'h00)
    else $error("memory write without cause or to null");

  COV_CALL: cover property (exec_call ##1 exec_call);
  COV_RET: cover property (exec_return ##1 exec_return);
  COV_MEMWR: cover property (mem_wr_q);
endmodule // cop_core_chk

bind cop_core_ctrl cop_core_chk u_chk (.ref_clk(ref_clk), .rst(rst), .exec_option_load(exec_option_load),
  .exec_jump(exec_jump), .exec_call(exec_call), .exec_return(exec_return), .exec_pcl_write(exec_pcl_write),
  .instr_addr(instr_addr), .instr_literal(instr_literal), .alu_result(alu_result), .work_reg(work_reg),
  .file_wr(file_wr), .mem_wr_q(mem_wr_q), .mem_addr_q(mem_addr_q), .program_counter_q(program_counter_q),
  .work_load_q(work_load_q), .work_data_q(work_data_q), .oscillator_trim_q(oscillator_trim_q),
  .pullup_en_q(pullup_en_q), .prescaler_rate_q(prescaler_rate_q));

// file: tb/cop_core_ctrl_bench.sv
`timescale 1ns/1ps
`include "cop_defs.vh"

module cop_core_ctrl_bench;
  reg        ref_clk = 1'b0;
  reg        rst = 1'b1;
  reg  [5:0] op = 6'h00;
  reg  [8:0] v = 9'h000;
  reg        fw = 1'b0;
  reg  [4:0] fa = 5'h00;
  reg  [5:0] chg = 6'h00;
  reg        clk_pin = 1'b0;
  reg        cyc = 1'b0;
  reg        wdt = 1'b0;
  wire [7:0] file_rdata_q, mem_wdata_q, work_data_q, oscillator_trim_q;
  wire       mem_wr_q, work_load_q, wake_q, counter_inc_q, watchdog_inc_q;
  wire [4:0] mem_addr_q;
  wire [9:0] program_counter_q;
  wire [5:0] pullup_en_q, dir_q;
  wire [2:0] prescaler_rate_q;
  integer    errors = 0;
  integer    n_checks = 0;
  integer    i;
  integer    k;
  integer    n_cnt = 0;
  integer    n_wdt = 0;

  always #10 ref_clk = ~ref_clk;

  cop_core_ctrl dut (.ref_clk(ref_clk), .rst(rst), .exec_option_load(op[0]), .exec_jump(op[1]),
    .exec_call(op[2]), .exec_return(op[3]), .exec_pcl_write(op[4]), .exec_dir_load(op[5]),
    .instr_addr(v), .instr_literal(v[7:0]), .alu_result(v[7:0]), .work_reg(v[7:0]),
    .file_wr(fw), .file_addr(fa), .file_wdata(v[7:0]), .file_rdata_q(file_rdata_q),
    .mem_wr_q(mem_wr_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_rdata(8'h3c),
    .program_counter_q(program_counter_q), .work_load_q(work_load_q), .work_data_q(work_data_q),
    .oscillator_trim_q(oscillator_trim_q), .pin_change(chg), .counter_clock_pin(clk_pin),
    .cycle_tick(cyc), .watchdog_tick(wdt), .pullup_en_q(pullup_en_q), .wake_q(wake_q), .dir_q(dir_q),
    .counter_inc_q(counter_inc_q), .watchdog_inc_q(watchdog_inc_q), .prescaler_rate_q(prescaler_rate_q));

  // One cycle of stimulus, applied at the falling edge
  task step(input [5:0] o, input w, input [4:0] a, input [8:0] d);
    begin
      op = o;
      fw = w;
      fa = a;
      v = d;
      @(negedge ref_clk);
    end
  endtask

  // Tick both sources for n cycles with the pin at p, then drain the pipeline
  task run(input integer n, input p);
    begin
      op = 6'h00;
      clk_pin = p;
      n_cnt = 0;
      n_wdt = 0;
      for (k = 0; k < n + 4; k = k + 1) begin
        cyc = (k < n);
        wdt = (k < n);
        @(negedge ref_clk);
        n_cnt = n_cnt + counter_inc_q;
        n_wdt = n_wdt + watchdog_inc_q;
      end
    end
  endtask

  task chk(input [11:0] got, input [11:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  initial begin
    #(20 * 3000);
    errors = errors + 1;
    give_verdict;
  end

  initial begin
    repeat (5) @(negedge ref_clk);
    chk({2'h0, program_counter_q}, 12'h3ff);
    chk({9'h000, prescaler_rate_q}, 12'h007);
    chk({6'h00, pullup_en_q}, 12'h000);
    rst = 1'b0;
    step(6'h00, 1'b0, 5'h05, 9'h000);
    chk({2'h0, program_counter_q}, 12'h000);
    step(6'h02, 1'b0, 5'h05, 9'h123);
    chk({4'h0, file_rdata_q}, 12'h0fe);
    chk({2'h0, program_counter_q}, 12'h123);
    $display("reset test done");
    step(6'h01, 1'b0, 5'h00, 9'h000);
    step(6'h00, 1'b0, 5'h00, 9'h000);
    chk({10'h000, pullup_en_q[1:0]}, 12'h003);
    step(6'h20, 1'b0, 5'h00, 9'h03e);
    step(6'h00, 1'b0, 5'h00, 9'h000);
    chk({10'h000, pullup_en_q[1:0]}, 12'h002);
    step(6'h20, 1'b0, 5'h00, 9'h000);
    step(6'h01, 1'b0, 5'h00, 9'h020);
    step(6'h00, 1'b0, 5'h00, 9'h000);
    chk({11'h000, dir_q[2]}, 12'h001);
    chk({10'h000, pullup_en_q[1:0]}, 12'h000);
    for (i = 0; i < 8; i = i + 1) begin
      step(6'h01, 1'b0, 5'h00, {4'hc, 2'h1, i[2:0]});
      step(6'h00, 1'b0, 5'h00, 9'h000);
      chk({9'h000, prescaler_rate_q}, i[11:0]);
    end
    $display("option test done");
    step(6'h00, 1'b1, 5'h05, 9'h081);
    step(6'h00, 1'b0, 5'h05, 9'h000);
    chk({4'h0, file_rdata_q}, 12'h080);
    step(6'h00, 1'b1, 5'h03, 9'h020);
    step(6'h02, 1'b0, 5'h00, 9'h1a5);
    chk({2'h0, program_counter_q}, 12'h3a5);
    step(6'h10, 1'b0, 5'h00, 9'h077);
    chk({2'h0, program_counter_q}, 12'h277);
    step(6'h00, 1'b1, 5'h03, 9'h000);
    step(6'h02, 1'b0, 5'h00, 9'h1ff);
    chk({2'h0, program_counter_q}, 12'h1ff);
    step(6'h00, 1'b0, 5'h00, 9'h000);
    chk({2'h0, program_counter_q}, 12'h200);
    $display("counter test done");
    step(6'h02, 1'b0, 5'h00, 9'h040);
    step(6'h04, 1'b0, 5'h00, 9'h010);
    step(6'h04, 1'b0, 5'h00, 9'h020);
    step(6'h04, 1'b0, 5'h00, 9'h030);
    chk({2'h0, program_counter_q}, 12'h030);
    step(6'h08, 1'b0, 5'h00, 9'h0a1);
    chk({2'h0, program_counter_q}, 12'h021);
    chk({3'h0, work_load_q, work_data_q}, 12'h1a1);
    step(6'h08, 1'b0, 5'h00, 9'h0a2);
    chk({2'h0, program_counter_q}, 12'h011);
    step(6'h08, 1'b0, 5'h00, 9'h0a3);
    chk({2'h0, program_counter_q}, 12'h011);
    $display("stack test done");
    step(6'h00, 1'b1, 5'h04, 9'h01f);
    step(6'h00, 1'b1, 5'h00, 9'h099);
    chk({mem_wr_q, 2'h0, mem_addr_q, 4'h0}, 12'h9f0);
    chk({4'h0, mem_wdata_q}, 12'h099);
    step(6'h00, 1'b0, 5'h00, 9'h000);
    chk({4'h0, file_rdata_q}, 12'h03c);
    step(6'h00, 1'b0, 5'h04, 9'h000);
    step(6'h00, 1'b1, 5'h04, 9'h0e0);
    chk({4'h0, file_rdata_q}, 12'h0ff);
    step(6'h00, 1'b1, 5'h00, 9'h055);
    chk({11'h000, mem_wr_q}, 12'h000);
    step(6'h00, 1'b0, 5'h00, 9'h000);
    step(6'h00, 1'b0, 5'h00, 9'h000);
    chk({4'h0, file_rdata_q}, 12'h000);
    $display("indirect test done");
    step(6'h01, 1'b0, 5'h00, 9'h001);
    run(16, 1'b0);
    chk(n_cnt[11:0], 12'h004);
    chk(n_wdt[11:0], 12'h010);
    step(6'h01, 1'b0, 5'h00, 9'h00b);
    run(16, 1'b0);
    chk(n_cnt[11:0], 12'h010);
    chk(n_wdt[11:0], 12'h002);
    step(6'h01, 1'b0, 5'h00, 9'h028);
    run(8, 1'b1);
    chk(n_cnt[11:0], 12'h001);
    chk(n_wdt[11:0], 12'h008);
    step(6'h01, 1'b0, 5'h00, 9'h038);
    run(4, 1'b0);
    chk(n_cnt[11:0], 12'h001);
    $display("tick test done");
    step(6'h20, 1'b0, 5'h00, 9'h03f);
    chg = 6'h02;
    repeat (3) step(6'h00, 1'b0, 5'h00, 9'h000);
    chk({11'h000, wake_q}, 12'h001);
    step(6'h20, 1'b0, 5'h00, 9'h03d);
    step(6'h00, 1'b0, 5'h00, 9'h000);
    chk({11'h000, wake_q}, 12'h000);
    step(6'h20, 1'b0, 5'h00, 9'h03f);
    step(6'h01, 1'b0, 5'h00, 9'h080);
    step(6'h00, 1'b0, 5'h00, 9'h000);
    chk({11'h000, wake_q}, 12'h000);
    chg = 6'h00;
    $display("wake test done");
    rst = 1'b1;
    step(6'h00, 1'b0, 5'h00, 9'h000);
    chk({2'h0, program_counter_q}, 12'h3ff);
    rst = 1'b0;
    step(6'h00, 1'b0, 5'h00, 9'h000);
    chk({2'h0, program_counter_q}, 12'h000);
    chk({9'h000, prescaler_rate_q}, 12'h007);
    $display("second reset test done");
    give_verdict;
  end
endmodule // cop_core_ctrl_bench
